// >>> verilog/usi_top.v
// Status LEDs, host word block and battery logic of the motion unit
//
// Operation
// - Run LED is off on failed startup or fatal error, flashes during discovery, else steady while ready and off otherwise.
// - Controller fault LED is off normally, flashes on startup hardware error or low battery, steady on log error.
// - Host comm fault LED is lit while host communication has failed.
// - Drive active LED is lit while a servo drive is being operated.
// - Eight LEDs show input bank n for selector 0-3 and output bank n-4 for 4-7, LED k bit k.
// - A 4-bit unit number 0 to f is read from the selector switch and must be unique on the host.
// - The unit uses 25 host words starting at 1500 plus 25 times the unit number.
// - Low battery flashes the fault LED, raises the battery-low flag and bit 3 of status word n+2.
// - Installing a new battery clears the low-battery flag and its flashing.
// - A software request copies programs, variables and tables from backed RAM to flash.
// - The encoder port offers five modes: incremental in, two absolute serial, encoder out, stepper.
`timescale 1ns/1ps
`include "usi_map.vh"
module usi_top (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_n_in,
   // Unit state from the processor
   input  wire        startup_fail_in,
   input  wire        fatal_error_in,
   input  wire        discovery_busy_in,
   input  wire        ready_in,
   input  wire        startup_hw_error_in,
   input  wire        error_log_fault_in,
   input  wire        host_comm_fail_in,
   input  wire        drive_operating_in,
   input  wire        network_bus_fault_in,
   // General-purpose LED source data
   input  wire [2:0]  display_sel_in,
   input  wire [31:0] gp_inputs_in,
   input  wire [31:0] gp_outputs_in,
   // Pins: unit switch and battery monitor
   input  wire [3:0]  unit_switch_in,
   input  wire        battery_low_pin_in,
   // Host word block access
   input  wire [15:0] host_word_addr_in,
   // Flash save requests
   input  wire        save_program_to_flash_in,
   input  wire        save_variables_to_flash_in,
   input  wire        copy_done_in,
   // Encoder mode
   input  wire [2:0]  encoder_mode_in,
   // Status LEDs
   output reg         run_led_out,
   output reg         controller_fault_led_out,
   output reg         host_comm_fault_led_out,
   output reg         drive_active_led_out,
   output reg         network_fault_led_out,
   output reg  [7:0]  gp_led_out,
   // Host word block
   output reg  [3:0]  unit_number_out,
   output reg  [15:0] word_base_out,
   output reg         host_word_hit_out,
   output reg  [4:0]  host_word_ofs_out,
   output reg  [15:0] status_word_out,
   output reg  [15:0] status_word_addr_out,
   // Battery and flash copy
   output reg         battery_low_out,
   output reg         copy_busy_out,
   output reg  [2:0]  copy_item_out,
   // Encoder port mode
   output reg  [4:0]  encoder_mode_onehot_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Timebase and pin synchronisers

   wire       flash;
   wire [3:0] unit_sw;
   wire       batt_pin;

   // Shared flash phase
   // one flash source
   usi_flash_gen u_flash (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .flash_out (flash)
   );

   // Switch and battery pins cross into the clock domain
   usi_sync3 #(.W(5)) u_sync (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .pin_in    ({battery_low_pin_in, unit_switch_in}),
      .clean_out ({batt_pin, unit_sw})
   );

   ////////////////////////////////////////////////////////////////////////////
   // Battery low flag

   // Set by the monitor, cleared when a good battery is seen again
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         battery_low_out <= 1'b0;
      end else if (batt_pin) begin
         battery_low_out <= 1'b1;
      end else begin
         battery_low_out <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status LEDs

   // Registered LED drive
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         run_led_out              <= 1'b0;
         controller_fault_led_out <= 1'b0;
         host_comm_fault_led_out  <= 1'b0;
         drive_active_led_out     <= 1'b0;
         network_fault_led_out    <= 1'b0;
      end else begin
         if (startup_fail_in || fatal_error_in) begin
            run_led_out <= 1'b0;
         end else if (discovery_busy_in) begin
            run_led_out <= flash;
         end else begin
            run_led_out <= ready_in;
         end
         if (error_log_fault_in) begin
            controller_fault_led_out <= 1'b1;
         end else if (startup_hw_error_in || battery_low_out) begin
            controller_fault_led_out <= flash;
         end else begin
            controller_fault_led_out <= 1'b0;
         end
         host_comm_fault_led_out <= host_comm_fail_in;
         drive_active_led_out    <= drive_operating_in;
         network_fault_led_out   <= network_bus_fault_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // General-purpose LEDs

   reg [31:0] gp_src;

   always @* begin
      if (display_sel_in[`USI_SEL_OUT_BIT]) begin
         gp_src = gp_outputs_in;
      end else begin
         gp_src = gp_inputs_in;
      end
   end

   // Pick byte n of the chosen word, LED k shows bit k
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gp_led_out <= 8'h00;
      end else begin
         gp_led_out <= gp_src[{display_sel_in[1:0], 3'h0} +: 8];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Unit number and host word block

   wire [15:0] next_base = `USI_WORD_BASE + {12'h000, unit_sw} * `USI_WORDS_PER_UNIT;
   wire [15:0] word_diff = host_word_addr_in - word_base_out;

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         unit_number_out      <= 4'h0;
         word_base_out        <= `USI_WORD_BASE;
         status_word_addr_out <= `USI_WORD_BASE + `USI_STATUS_OFS;
      end else begin
         unit_number_out      <= unit_sw;
         word_base_out        <= next_base;
         status_word_addr_out <= next_base + `USI_STATUS_OFS;
      end
   end

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         host_word_hit_out <= 1'b0;
         host_word_ofs_out <= 5'h00;
      end else if (host_word_addr_in >= word_base_out &&
                   word_diff <= `USI_WORD_LAST_OFS) begin
         host_word_hit_out <= 1'b1;
         host_word_ofs_out <= word_diff[4:0];
      end else begin
         host_word_hit_out <= 1'b0;
         host_word_ofs_out <= 5'h00;
      end
   end

   // Status word n+2 contents
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_word_out <= 16'h0000;
      end else begin
         status_word_out <= 16'h0000;
         status_word_out[`USI_BATT_BIT] <= battery_low_out;
         status_word_out[`USI_HOST_FAIL_BIT] <= host_comm_fail_in;
         status_word_out[`USI_NET_FAULT_BIT] <= network_bus_fault_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flash save sequencer

   localparam [2:0] CP_IDLE = 3'h1;
   localparam [2:0] CP_PROG = 3'h2;
   localparam [2:0] CP_VARS = 3'h4;

   reg [2:0] cp_state;
   reg [2:0] next_cp_state;
   reg       vars_pending;

   always @* begin
      next_cp_state = cp_state;
      case (cp_state)
         CP_IDLE: begin
            if (save_program_to_flash_in) begin
               next_cp_state = CP_PROG;
            end else if (save_variables_to_flash_in) begin
               next_cp_state = CP_VARS;
            end
         end
         CP_PROG: begin
            if (copy_done_in) begin
               // A variables request in the final cycle is not lost
               next_cp_state = (vars_pending || save_variables_to_flash_in) ? CP_VARS : CP_IDLE;
            end
         end
         CP_VARS: begin
            if (copy_done_in) begin
               next_cp_state = CP_IDLE;
            end
         end
         default: begin
            next_cp_state = CP_IDLE;
         end
      endcase
   end

   // State and queued variable request
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cp_state     <= CP_IDLE;
         vars_pending <= 1'b0;
      end else begin
         cp_state <= next_cp_state;
         // Clear first: a request served at once must not stay queued for later
         if (next_cp_state == CP_VARS) begin
            vars_pending <= 1'b0;
         end else if (save_variables_to_flash_in && cp_state != CP_VARS) begin
            vars_pending <= 1'b1;
         end
      end
   end

   // Copy status: item bit0 programs+tables, bit1 variables
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         copy_busy_out <= 1'b0;
         copy_item_out <= 3'h0;
      end else begin
         copy_busy_out <= (next_cp_state != CP_IDLE);
         copy_item_out <= {1'b0, next_cp_state[2], next_cp_state[1]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Encoder port mode

   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         encoder_mode_onehot_out <= 5'h01;
      end else if (encoder_mode_in == `USI_ENC_ABS_A) begin
         encoder_mode_onehot_out <= 5'h02;
      end else if (encoder_mode_in == `USI_ENC_SSI) begin
         encoder_mode_onehot_out <= 5'h04;
      end else if (encoder_mode_in == `USI_ENC_INC_OUT) begin
         encoder_mode_onehot_out <= 5'h08;
      end else if (encoder_mode_in == `USI_ENC_STEP_OUT) begin
         encoder_mode_onehot_out <= 5'h10;
      end else begin
         encoder_mode_onehot_out <= 5'h01;
      end
   end

endmodule

// >>> common/usi_map.vh
// Constants for the unit status indication block
`ifndef USI_MAP_VH
`define USI_MAP_VH
`define USI_CLK_HZ          10000000
`define USI_FLASH_MS        500
`define USI_FLASH_CYCLES    ((`USI_CLK_HZ / 1000) * `USI_FLASH_MS)
`define USI_FLASH_CNT_W     23
`define USI_WORD_BASE       16'h05dc
`define USI_WORDS_PER_UNIT  16'h0019
`define USI_WORD_LAST_OFS   16'h0018
`define USI_STATUS_OFS      16'h0002
`define USI_BATT_BIT        4'h3
`define USI_HOST_FAIL_BIT   4'h0
`define USI_NET_FAULT_BIT   4'h1
`define USI_SEL_OUT_BIT     2
`define USI_ENC_INC_IN      3'h0
`define USI_ENC_ABS_A       3'h1
`define USI_ENC_SSI         3'h2
`define USI_ENC_INC_OUT     3'h3
`define USI_ENC_STEP_OUT    3'h4
`endif

// >>> verilog/usi_flash_gen.v
// Shared flash timebase for all blinking indicators
`timescale 1ns/1ps
`include "usi_map.vh"
module usi_flash_gen (
   // Clock and reset
   input  wire clk_in,
   input  wire rst_n_in,
   // Flash phase
   output reg  flash_out
);
   // Terminal count is formed at full width, then sliced to the counter width
   localparam [31:0]                 HALF_LAST_FULL = `USI_FLASH_CYCLES - 1;
   localparam [`USI_FLASH_CNT_W-1:0] HALF_LAST      = HALF_LAST_FULL[`USI_FLASH_CNT_W-1:0];
   reg [`USI_FLASH_CNT_W-1:0] count;

   // Toggle every half period, one second full period
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count     <= {`USI_FLASH_CNT_W{1'b0}};
         flash_out <= 1'b0;
      end else if (count == HALF_LAST) begin
         count     <= {`USI_FLASH_CNT_W{1'b0}};
         flash_out <= ~flash_out;
      end else begin
         count <= count + 1'b1;
      end
   end
endmodule

// >>> verilog/usi_sync3.v
// Three-stage synchroniser with agreement filter for a pin bus
`timescale 1ns/1ps
module usi_sync3 #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clk_in,
   input  wire         rst_n_in,
   // Pin side and clean side
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] clean_out
);
   reg [W-1:0] s1;
   reg [W-1:0] s2;
   reg [W-1:0] s3;

   // Shift chain
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1 <= {W{1'b0}};
         s2 <= {W{1'b0}};
         s3 <= {W{1'b0}};
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Accept a change once second and third stage agree, else each bit holds
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clean_out <= {W{1'b0}};
      end else begin
         clean_out <= (s3 & ~(s2 ^ s3)) | (clean_out & (s2 ^ s3));
      end
   end
endmodule

// >>> test/usi_asserts.sv
// Concurrent checks on the unit status block ports
`timescale 1ns/1ps
module usi_asserts (
   // Clock, reset and inputs
   input wire        clk_in,
   input wire        rst_n_in,
   input wire        startup_fail_in,
   input wire        fatal_error_in,
   input wire        error_log_fault_in,
   input wire        host_comm_fail_in,
   input wire [2:0]  display_sel_in,
   input wire [31:0] gp_inputs_in,
   input wire [31:0] gp_outputs_in,
   input wire [2:0]  encoder_mode_in,
   input wire        save_program_to_flash_in,
   // Watched outputs
   input wire        run_led_out,
   input wire        controller_fault_led_out,
   input wire        host_comm_fault_led_out,
   input wire [7:0]  gp_led_out,
   input wire [15:0] status_word_out,
   input wire        battery_low_out,
   input wire        copy_busy_out,
   input wire [2:0]  copy_item_out,
   input wire [4:0]  encoder_mode_onehot_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Expected LED byte and mode vector
   wire [31:0] gp_src = display_sel_in[2] ? gp_outputs_in : gp_inputs_in;
   wire [7:0]  gp_pick = gp_src[8 * display_sel_in[1:0] +: 8];
   wire [4:0]  enc_pick = (encoder_mode_in > 3'h4) ? 5'h01 : 5'h01 << encoder_mode_in;

   run_off_a: assert property ((startup_fail_in || fatal_error_in) |=> !run_led_out)
      else $error("run LED lit in failure");
   log_err_a: assert property (error_log_fault_in |=> controller_fault_led_out)
      else $error("fault LED dark on log error");
   host_led_a: assert property (1 |=> host_comm_fault_led_out == $past(host_comm_fail_in))
      else $error("host LED wrong");
   gp_mux_a: assert property (1 |=> gp_led_out == $past(gp_pick))
      else $error("gp LEDs wrong bank");
   batt_set_a: assert property (battery_low_out [*2] |-> status_word_out[3])
      else $error("status bit3 not set");
   batt_clear_a: assert property ((!battery_low_out) [*2] |-> !status_word_out[3])
      else $error("status bit3 not cleared");
   copy_start_a: assert property (save_program_to_flash_in && !copy_busy_out |=>
      copy_busy_out && copy_item_out == 3'h1) else $error("program copy not started");
   enc_mode_a: assert property (1 |=> encoder_mode_onehot_out == $past(enc_pick))
      else $error("encoder mode wrong");
   cover property (copy_busy_out && copy_item_out == 3'h2);
   cover property (battery_low_out);
   cover property (controller_fault_led_out);
endmodule
bind usi_top usi_asserts usi_asserts_inst (.*);

// >>> test/usi_host_model.sv
// Host side model: word addresses and copy completion
`timescale 1ns/1ps
module usi_host_model (
   // Clock and requests from the bench
   input  wire        clk_in,
   input  wire        addr_valid_in,
   input  wire [15:0] addr_req_in,
   input  wire        copy_busy_in,
   input  wire [3:0]  lat_in,
   // Toward the block
   output reg  [15:0] host_word_addr_out,
   output reg         copy_done_out
);
   reg [3:0] wait_cnt = 4'h0;
   initial host_word_addr_out = 16'h0000;
   initial copy_done_out = 1'b0;
   // host word access
   // Idle address toggles every cycle; one done pulse per copy after lat_in cycles
   always @(posedge clk_in) begin
      host_word_addr_out <= addr_valid_in ? addr_req_in : ~host_word_addr_out;
      copy_done_out <= copy_busy_in && wait_cnt == lat_in;
      wait_cnt <= (!copy_busy_in || wait_cnt == lat_in) ? 4'h0 : wait_cnt + 4'h1;
   end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the unit status block
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {int id; logic [15:0] v;} usi_note_t;
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [8:0]  st = 9'h000;
   logic [2:0]  sel = 3'h0, enc = 3'h0;
   logic [31:0] gin = 32'h0, gout = 32'h0, r = 32'h00005c5b;
   logic [3:0]  unit = 4'h0, lat = 4'h6;
   logic        bpin = 1'b0, sp = 1'b0, sv = 1'b0, avld = 1'b0;
   logic [15:0] areq = 16'h0000, b;
   wire  [15:0] addr, base, sw, swa;
   wire  [7:0]  gp;
   wire  [4:0]  led, ofs, eoh;
   wire  [3:0]  un;
   wire  [2:0]  item;
   wire         done, hit, bat, busy;
   usi_note_t   q[$];
   usi_note_t   n;
   int          mismatches = 0, n_compared = 0, i, j;
   int          at[4] = '{24, 25, -1, 0};
   logic [15:0] ht[4] = '{16'h0038, 16'h0000, 16'h0000, 16'h0020};
   // State vector and LED result: {st, run, fault, host, drive, net}
   logic [13:0] lt[11] = '{14'h0110, 14'h0120, 14'h0140, 14'h0180, 14'h0408, 14'h0608,
                           14'h0200, 14'h0804, 14'h1002, 14'h2001, 14'h3d1f};
   string       nm[8] = '{"led", "gp", "base", "hit", "swa", "batu", "copy", "enc"};

   always #50 clk_in = ~clk_in;

   usi_top usi_top_inst (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .startup_fail_in(st[0]), .fatal_error_in(st[1]),
      .discovery_busy_in(st[2]), .ready_in(st[3]), .startup_hw_error_in(st[4]),
      .error_log_fault_in(st[5]), .host_comm_fail_in(st[6]), .drive_operating_in(st[7]),
      .network_bus_fault_in(st[8]), .display_sel_in(sel), .gp_inputs_in(gin),
      .gp_outputs_in(gout), .unit_switch_in(unit), .battery_low_pin_in(bpin),
      .host_word_addr_in(addr), .save_program_to_flash_in(sp),
      .save_variables_to_flash_in(sv), .copy_done_in(done), .encoder_mode_in(enc),
      .run_led_out(led[4]), .controller_fault_led_out(led[3]),
      .host_comm_fault_led_out(led[2]), .drive_active_led_out(led[1]),
      .network_fault_led_out(led[0]), .gp_led_out(gp), .unit_number_out(un),
      .word_base_out(base), .host_word_hit_out(hit), .host_word_ofs_out(ofs),
      .status_word_out(sw), .status_word_addr_out(swa), .battery_low_out(bat),
      .copy_busy_out(busy), .copy_item_out(item), .encoder_mode_onehot_out(eoh));
   usi_host_model usi_host_model_inst (
      .clk_in(clk_in), .addr_valid_in(avld), .addr_req_in(areq), .copy_busy_in(busy),
      .lat_in(lat), .host_word_addr_out(addr), .copy_done_out(done));

   function automatic logic [15:0] seen(input int id);
      case (id)
         0: return {11'h000, led};
         1: return {8'h00, gp};
         2: return base;
         3: return hit ? {11'h001, ofs} : 16'h0000;
         4: return swa;
         5: return {10'h000, sw[3], bat, un};
         6: return {12'h000, busy, item};
         default: return {11'h000, eoh};
      endcase
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic ex(input int id, input logic [15:0] v);
      q.push_back('{id, v});
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_in);
   endtask
   task automatic chk(input int id, input logic [15:0] e);
      n_compared++;
      if (seen(id) !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm[id], e, seen(id));
      end
   endtask
   task automatic end_of_test;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Every queued note is compared once outputs have settled
   always @(negedge clk_in) begin
      while (q.size() > 0) begin
         n = q.pop_front();
         chk(n.id, n.v);
      end
   end

   // Watchdog well beyond the expected run
   initial begin
      #500_000;
      mismatches++;
      end_of_test;
   end

   // Main sequence, inputs change on the falling edge
   initial begin
      tick(6);
      @(negedge clk_in) rst_n_in = 1'b1;
      foreach (lt[k]) begin
         @(negedge clk_in) st = lt[k][13:5];
         tick(2);
         ex(0, {11'h000, lt[k][4:0]});
      end
      @(negedge clk_in) st = 9'h000;
      $display("status LED test done");
      for (i = 0; i < 8; i++) begin
         repeat (32) r = lfsr(r);
         @(negedge clk_in) gin = r;
         repeat (32) r = lfsr(r);
         gout = r;
         sel = i[2:0];
         tick(2);
         b = 16'((i > 3 ? gout : gin) >> (8 * (i % 4)));
         ex(1, {8'h00, b[7:0]});
      end
      $display("general LED test done");
      @(negedge clk_in) avld = 1'b1;
      for (i = 0; i < 16; i++) begin
         @(negedge clk_in) unit = i[3:0];
         tick(8);
         b = 16'h05dc + 16'h0019 * 16'(i);
         ex(2, b);
         ex(4, b + 16'h0002);
         ex(5, 16'(i));
         for (j = 0; j < 4; j++) begin
            @(negedge clk_in) areq = b + 16'(at[j]);
            tick(3);
            ex(3, ht[j]);
         end
      end
      @(negedge clk_in) avld = 1'b0;
      $display("word block test done");
      bpin = 1'b1;
      tick(8);
      ex(5, 16'h003f);
      @(negedge clk_in) bpin = 1'b0;
      tick(8);
      ex(5, 16'h000f);
      $display("battery test done");
      @(negedge clk_in) sp = 1'b1;
      @(negedge clk_in) sp = 1'b0;
      sv = 1'b1;
      @(negedge clk_in) sv = 1'b0;
      tick(1);
      ex(6, 16'h0009);
      tick(9);
      ex(6, 16'h000a);
      tick(8);
      ex(6, 16'h0000);
      // Lone variables copy, then a program copy that must not repeat it
      @(negedge clk_in) sv = 1'b1;
      @(negedge clk_in) sv = 1'b0;
      tick(1);
      ex(6, 16'h000a);
      tick(9);
      ex(6, 16'h0000);
      @(negedge clk_in) sp = 1'b1;
      @(negedge clk_in) sp = 1'b0;
      tick(9);
      ex(6, 16'h0000);
      $display("flash copy test done");
      for (i = 0; i < 8; i++) begin
         @(negedge clk_in) enc = i[2:0];
         tick(2);
         ex(7, (i < 5) ? 16'h0001 << i : 16'h0001);
      end
      $display("encoder mode test done");
      tick(2);
      end_of_test;
   end
endmodule
